// ===== src/power_profile_pkg.sv
package power_profile_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  // Printed offsets are not all multiples of four, so they are indices.
  localparam logic [7:0]  POWER_CFG_INDEX       = 8'h90;
  localparam logic [7:0]  DUTY_PROFILE_INDEX    = 8'h96;
  localparam logic [7:0]  STEP_CTRL_INDEX       = 8'h97;
  localparam logic [9:0]  POWER_CFG_ADDR        = {POWER_CFG_INDEX, 2'b00};
  localparam logic [9:0]  DUTY_PROFILE_ADDR     = {DUTY_PROFILE_INDEX, 2'b00};
  localparam logic [9:0]  STEP_CTRL_ADDR        = {STEP_CTRL_INDEX, 2'b00};
  localparam logic [31:0] POWER_CFG_RESET       = 32'h0000_0000;
  localparam logic [31:0] DUTY_PROFILE_RESET    = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ         = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------------------
  localparam int PARITY_BIT          = 31;
  localparam int MAX_SPEED_LSB       = 15;
  localparam int MAX_SPEED_W         = 16;
  localparam int DEAD_BAND_BIT       = 14;
  localparam int MAX_POWER_LSB       = 4;
  localparam int MAX_POWER_W         = 10;
  localparam int HYST_LSB            = 2;
  localparam int HYST_W              = 2;
  localparam int MODE_LSB            = 0;
  localparam int MODE_W              = 2;
  localparam int STEP0_LSB           = 28;
  localparam int STEP_W              = 3;
  localparam int STEP_COUNT          = 8;
  localparam int ALGO_RESERVED_W     = 7;
  localparam int STEP_DIV_W          = 16;

  // Duty in tenths of a percent per step code, 0 .. 99 %.
  localparam int DUTY_W = 10;

  // Hysteresis in tenths of a percent.
  localparam int HYST_PCT_W = 7;

  typedef enum logic [1:0]
  {
    REG_MODE_OFF         = 2'h0,
    REG_MODE_CLOSED_LOOP = 2'h1,
    REG_MODE_LIMIT       = 2'h2,
    REG_MODE_RESERVED    = 2'h3
  } power_mode_t;

endpackage : power_profile_pkg

// ===== src/duty_step_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

module duty_step_sequencer
  import power_profile_pkg::*;
(
  // Clock, reset and enable
  input  wire  logic                          clk_i,
  input  wire  logic                          rst_i,
  input  wire  logic                          ce_i,
  // Profile and timing
  input  wire  logic [STEP_COUNT*STEP_W-1:0]  steps_i,
  input  wire  logic [STEP_DIV_W-1:0]         sub_len_i,
  input  wire  logic                          two_phase_i,
  input  wire  logic                          commutate_i,
  // Current step
  output logic       [2:0]                    step_idx_o,
  output logic       [STEP_W-1:0]             step_code_o
);

  logic [2:0]            idx_q;
  logic [STEP_DIV_W-1:0] cnt_q;
  logic                  run_q;

  // -------------------------------------------------------------------------
  // Step walk
  // -------------------------------------------------------------------------
  // A commutation restarts at step 0; each sub-interval moves one step on and
  // the walk parks on step 7 until the next commutation; two-phase dropping returns it to step 0.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idx_q <= 3'h0;
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!two_phase_i)
      begin
        idx_q <= 3'h0;
        cnt_q <= '0;
        run_q <= 1'b0;
      end
      else if (commutate_i)
      begin
        idx_q <= 3'h0; // RQ12
        cnt_q <= '0;
        run_q <= 1'b1;
      end
      else if (run_q)
      begin
        if (cnt_q >= sub_len_i)
        begin
          cnt_q <= '0;
          if (idx_q == 3'h7)
            run_q <= 1'b0;
          else
            idx_q <= idx_q + 3'h1; // RQ12
        end
        else
          cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      step_idx_o  <= 3'h0;
      step_code_o <= '0;
    end
    else if (ce_i)
    begin
      step_idx_o  <= idx_q;
      step_code_o <= steps_i[(STEP_COUNT-1-idx_q)*STEP_W +: STEP_W];
    end
  end

endmodule : duty_step_sequencer

`default_nettype wire

// ===== src/power_limit_regs.sv
//
// Notes on behaviour
// RQ1 - Power word at index 90h, resets to zero so regulation starts off.
// RQ2 - Bits 30..15 hold speed ceiling code; hertz equals code divided by 16.
// RQ3 - Bit 14 turns dead-band correction on when one, off when zero.
// RQ4 - Bits 13..4 hold power ceiling code; watts equals code divided by 4.
// RQ5 - Bits 3..2 pick hysteresis: 5, 7.5, 10, 12.5 percent.
// RQ6 - Bits 1..0 pick scheme: off, closed loop, limit, reserved.
// RQ7 - Duty profile word at index 96h, resets to zero.
// RQ8 - Eight 3-bit step codes, step 0 at bits 30..28 down to bits 9..7.
// RQ9 - Step codes map to 0, 50, 75, 83.75, 87.5, 93.75, 97.5, 99 percent.
// RQ10 - Profile bits 6..0 are reserved for algorithm updates, no user function.
// RQ11 - Bit 31 of each word is parity, stored and returned like others.
// RQ12 - Step codes apply in ascending order over commutation sub-intervals.
//
`timescale 1ns/100ps
`default_nettype none

module power_limit_regs
  import power_profile_pkg::*;
(
  // Clock, reset, enable
  input  wire  logic                    clk_i,
  input  wire  logic                    rst_i,
  input  wire  logic                    ce_i,
  // Wishbone slave
  input  wire  logic                    cyc_i,
  input  wire  logic                    stb_i,
  input  wire  logic                    we_i,
  input  wire  logic [9:0]              adr_i,
  input  wire  logic [3:0]              sel_i,
  input  wire  logic [31:0]             dat_i,
  output logic       [31:0]             dat_o,
  output logic                          ack_o,
  // Algorithm side
  input  wire  logic                    two_phase_i,
  input  wire  logic                    commutate_i,
  output logic       [MAX_SPEED_W-1:0]  max_speed_o,
  output logic                          dead_band_correction_on_o,
  output logic       [MAX_POWER_W-1:0]  max_power_o,
  output logic       [HYST_PCT_W-1:0]   power_regulation_hysteresis_o,
  output logic                          closed_loop_power_o,
  output logic                          power_limit_o,
  output logic       [2:0]              step_idx_o,
  output logic       [DUTY_W-1:0]       step_duty_o
);

  // -------------------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------------------
  // Duty in tenths of a percent; 83.75 and 93.75 are not whole tenths, so
  // they are kept to one decimal by truncation (837 and 937).
  function automatic logic [DUTY_W-1:0] duty_of(input logic [STEP_W-1:0] code);
    logic [DUTY_W-1:0] d;
    d = 10'h000;
    case (code) // RQ9
      3'h0: d = 10'h000;
      3'h1: d = 10'h1F4;
      3'h2: d = 10'h2EE;
      3'h3: d = 10'h345;
      3'h4: d = 10'h36B;
      3'h5: d = 10'h3A9;
      3'h6: d = 10'h3CF;
      default: d = 10'h3DE;
    endcase
    return d;
  endfunction : duty_of

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wr,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = wr[i*8 +: 8];
    return r;
  endfunction : merge

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  logic [31:0]           power_cfg_q;
  logic [31:0]           duty_profile_q;
  logic [STEP_DIV_W-1:0] sub_len_q;
  logic                  req;
  logic                  wr_en;
  logic [31:0]           rd_d;
  logic [STEP_W-1:0]     step_code;
  logic [MODE_W-1:0]     mode;
  logic [HYST_W-1:0]     hyst;
  logic [31:0]           sub_len_wr;

  // A function result cannot be part-selected, so the merged word is staged.
  assign sub_len_wr = merge({16'h0000, sub_len_q}, dat_i, sel_i);

  assign req   = cyc_i && stb_i && !ack_o;
  assign wr_en = req && we_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      power_cfg_q <= POWER_CFG_RESET; // RQ1
    else if (ce_i && wr_en && adr_i == POWER_CFG_ADDR)
      power_cfg_q <= merge(power_cfg_q, dat_i, sel_i); // RQ11
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      duty_profile_q <= DUTY_PROFILE_RESET; // RQ7
    else if (ce_i && wr_en && adr_i == DUTY_PROFILE_ADDR)
      // Reserved bits are stored for the algorithm but drive nothing here.
      duty_profile_q <= merge(duty_profile_q, dat_i, sel_i); // RQ10 RQ11
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sub_len_q <= '0;
    else if (ce_i && wr_en && adr_i == STEP_CTRL_ADDR)
      sub_len_q <= sub_len_wr[STEP_DIV_W-1:0];
  end

  // -------------------------------------------------------------------------
  // Bus answer
  // -------------------------------------------------------------------------
  // One wait-free cycle: ack the edge after the strobe, and drop it the next.
  always_comb
  begin
    if (adr_i == POWER_CFG_ADDR)
      rd_d = power_cfg_q;
    else if (adr_i == DUTY_PROFILE_ADDR)
      rd_d = duty_profile_q;
    else if (adr_i == STEP_CTRL_ADDR)
      rd_d = {16'h0000, sub_len_q};
    else
      rd_d = UNMAPPED_READ;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_o <= req;
      dat_o <= req ? rd_d : 32'h0000_0000;
    end
  end

  // -------------------------------------------------------------------------
  // Field decode
  // -------------------------------------------------------------------------
  assign mode = power_cfg_q[MODE_LSB +: MODE_W];
  assign hyst = power_cfg_q[HYST_LSB +: HYST_W];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      max_speed_o                   <= '0;
      dead_band_correction_on_o     <= 1'b0;
      max_power_o                   <= '0;
      // Register resets to code 0, so the decoded value is the 5 % step.
      power_regulation_hysteresis_o <= 7'h32;
      closed_loop_power_o           <= 1'b0;
      power_limit_o                 <= 1'b0;
    end
    else if (ce_i)
    begin
      max_speed_o               <= power_cfg_q[MAX_SPEED_LSB +: MAX_SPEED_W]; // RQ2
      dead_band_correction_on_o <= power_cfg_q[DEAD_BAND_BIT]; // RQ3
      max_power_o               <= power_cfg_q[MAX_POWER_LSB +: MAX_POWER_W]; // RQ4
      // Tenths of a percent: 50 + 25 per code.
      power_regulation_hysteresis_o <= 7'h32 + {hyst, 4'h0} + {2'h0, hyst, 3'h0}
                                       + {4'h0, hyst, 1'b0} - {5'h00, hyst}; // RQ5
      // Reserved code 3 behaves like off.
      closed_loop_power_o <= (mode == REG_MODE_CLOSED_LOOP); // RQ6
      power_limit_o       <= (mode == REG_MODE_LIMIT); // RQ6
    end
  end

  // -------------------------------------------------------------------------
  // Two-phase step sequencing
  // -------------------------------------------------------------------------
  duty_step_sequencer u_seq
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .steps_i     (duty_profile_q[STEP0_LSB+STEP_W-1 -: STEP_COUNT*STEP_W]), // RQ8
    .sub_len_i   (sub_len_q),
    .two_phase_i (two_phase_i),
    .commutate_i (commutate_i),
    .step_idx_o  (step_idx_o),
    .step_code_o (step_code)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      step_duty_o <= '0;
    else if (ce_i)
      step_duty_o <= duty_of(step_code); // RQ9 RQ12
  end

endmodule : power_limit_regs

`default_nettype wire

// ===== verification/power_limit_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module power_limit_regs_checker
  import power_profile_pkg::*;
(
  // Bus side
  input wire logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i,
  input wire logic [9:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i, dat_o,
  input wire logic        ack_o,
  // Algorithm side
  input wire logic        two_phase_i, commutate_i, dead_band_correction_on_o,
  input wire logic        closed_loop_power_o, power_limit_o,
  input wire logic [15:0] max_speed_o,
  input wire logic [9:0]  max_power_o, step_duty_o,
  input wire logic [6:0]  power_regulation_hysteresis_o,
  input wire logic [2:0]  step_idx_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o && ce_i;
  endsequence
  sequence s_kick;
    commutate_i && two_phase_i && ce_i;
  endsequence
  a_ack_follows: assert property (s_req |=> ack_o)
    else $error("request not acknowledged");
  a_ack_single: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack longer than one cycle");
  a_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  a_mode_excl: assert property (!(closed_loop_power_o && power_limit_o))
    else $error("two regulation schemes at once");
  a_hyst_legal: assert property (power_regulation_hysteresis_o inside {7'h32, 7'h4B, 7'h64, 7'h7D})
    else $error("hysteresis off table");
  a_duty_legal: assert property (step_duty_o inside {10'h000, 10'h1F4, 10'h2EE, 10'h345,
    10'h36B, 10'h3A9, 10'h3CF, 10'h3DE})
    else $error("duty off table");
  a_kick_index: assert property (s_kick |-> ##[1:2] step_idx_o == 3'h0)
    else $error("commutation did not restart steps");
  a_step_ascend: assert property ($changed(step_idx_o) |->
    step_idx_o == $past(step_idx_o) + 3'h1 || step_idx_o == 3'h0)
    else $error("step index out of order");
  a_idle_index: assert property ((!two_phase_i && ce_i) [*3] |-> step_idx_o == 3'h0)
    else $error("step walk outside two phase");
  a_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> !ack_o
    && max_speed_o == 16'h0 && max_power_o == 10'h0 && !closed_loop_power_o)
    else $error("outputs not cleared by reset");
endmodule : power_limit_regs_checker
bind power_limit_regs power_limit_regs_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .two_phase_i(two_phase_i),
  .commutate_i(commutate_i), .dead_band_correction_on_o(dead_band_correction_on_o),
  .closed_loop_power_o(closed_loop_power_o), .power_limit_o(power_limit_o),
  .max_speed_o(max_speed_o), .max_power_o(max_power_o), .step_duty_o(step_duty_o),
  .power_regulation_hysteresis_o(power_regulation_hysteresis_o), .step_idx_o(step_idx_o));
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import power_profile_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ce_i = 1;
  logic        two_phase_i = 0, commutate_i = 0, ack_o, dbc_o, cl_o, pl_o;
  logic [9:0]  adr_i = 10'h000, pwr_o, duty_o;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd, w;
  logic [15:0] spd_o;
  logic [6:0]  hys_o;
  logic [2:0]  idx_o;
  logic [9:0]  duty_tbl [8] = '{10'h000, 10'h1F4, 10'h2EE, 10'h345, 10'h36B, 10'h3A9,
                                10'h3CF, 10'h3DE};
  int          n_errors = 0, num_checks = 0;
  power_limit_regs i_power_limit_regs (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .two_phase_i(two_phase_i), .commutate_i(commutate_i),
    .max_speed_o(spd_o), .dead_band_correction_on_o(dbc_o), .max_power_o(pwr_o),
    .power_regulation_hysteresis_o(hys_o), .closed_loop_power_o(cl_o),
    .power_limit_o(pl_o), .step_idx_o(idx_o), .step_duty_o(duty_o));
  initial forever #12.5 clk_i = ~clk_i;
  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One classic cycle, then a released cycle before the next request.
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i  <= wr;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    we_i  <= 0;
    @(posedge clk_i);
  endtask : bus
  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (6000) @(posedge clk_i);
    n_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    bus(0, POWER_CFG_ADDR, 0);
    check("power_reset", rd, 0);
    bus(0, DUTY_PROFILE_ADDR, 0);
    check("profile_reset", rd, 0);
    w = {1'b1, 16'hA5C3, 1'b1, 10'h2B7, 2'h2, 2'h1};
    bus(1, POWER_CFG_ADDR, w);
    bus(0, POWER_CFG_ADDR, 0);
    check("power_word", rd, w);
    check("speed", spd_o, 16'hA5C3);
    check("dead_band", dbc_o, 1);
    check("power", pwr_o, 10'h2B7);
    bus(1, 10'h300, 32'hFFFF_FFFF);
    bus(0, 10'h300, 0);
    check("unmapped", rd, 0);
    bus(0, POWER_CFG_ADDR, 0);
    check("power_kept", rd, w);
    for (int m = 0; m < 4; m++)
    begin
      bus(1, POWER_CFG_ADDR, {28'h0, 2'(m), 2'(m)});
      check("hyst", hys_o, 32'h32 + 32'h19 * m);
      check("closed_loop", cl_o, m == 1);
      check("limit", pl_o, m == 2);
    end
    w = 32'h8000_0055;
    for (int k = 0; k < 8; k++)
      w[30-3*k -: 3] = 3'(k);
    bus(1, DUTY_PROFILE_ADDR, w);
    bus(0, DUTY_PROFILE_ADDR, 0);
    check("profile_word", rd, w);
    bus(1, STEP_CTRL_ADDR, 32'h4);
    two_phase_i <= 1;
    commutate_i <= 1;
    @(posedge clk_i);
    commutate_i <= 0;
    for (int k = 0; k < 8; k++)
    begin
      for (int t = 0; t < 40 && idx_o !== 3'(k); t++)
        @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      check("step_index", idx_o, k);
      check("step_duty", duty_o, duty_tbl[k]);
    end
    repeat (20) @(posedge clk_i);
    check("step_park", idx_o, 7);
    ce_i <= 0;
    two_phase_i <= 0;
    repeat (4) @(posedge clk_i);
    check("step_frozen", idx_o, 7);
    ce_i <= 1;
    repeat (4) @(posedge clk_i);
    check("step_idle", idx_o, 0);
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    bus(0, DUTY_PROFILE_ADDR, 0);
    check("profile_rereset", rd, 0);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
